// [core/ilf_core.sv]
// Local user bus flow control, burst checking and error signalling
`timescale 1ns/10ps
`default_nettype none
module ilf_core (
    // Clock and reset
    input wire logic mclk_in,
    input wire logic nrst_in,
    // Register port
    input wire logic [ilf_pkg::ADDR_W-1:0] reg_addr_in,
    input wire logic [ilf_pkg::DATA_W-1:0] reg_wdata_in,
    input wire logic reg_wr_in,
    input wire logic reg_rd_in,
    output logic [ilf_pkg::DATA_W-1:0] reg_rdata_out,
    output logic irq_out,
    // Transmit local user bus
    input wire logic tx_ena_in,
    input wire logic [ilf_pkg::WORD_W-1:0] tx_data_in,
    input wire logic tx_sop_in,
    input wire logic tx_eop_in,
    input wire logic [ilf_pkg::CHAN_W-1:0] tx_chan_in,
    input wire logic tx_bctl_in,
    output logic tx_backpress_out,
    output logic tx_ovf_out,
    output logic tx_underflow_out,
    output logic tx_burst_err_out,
    // Transmit link side
    output logic ln_tx_valid_out,
    output logic [ilf_pkg::WORD_W-1:0] ln_tx_data_out,
    output logic ln_tx_sop_out,
    output logic ln_tx_eop_out,
    output logic ln_tx_bcw_out,
    output logic [ilf_pkg::CHAN_W-1:0] ln_tx_chan_out,
    // Receive link side
    input wire logic ln_rx_valid_in,
    input wire logic [ilf_pkg::WORD_W-1:0] ln_rx_data_in,
    input wire logic ln_rx_sop_in,
    input wire logic ln_rx_eop_in,
    input wire logic ln_rx_err_in,
    // Receive local user bus
    input wire logic rx_rd_in,
    output logic rx_ena_out,
    output logic [ilf_pkg::WORD_W-1:0] rx_data_out,
    output logic rx_sop_out,
    output logic rx_eop_out,
    output logic rx_err_out,
    output logic rx_overflow_out
);
    ////////////////////////////////////////////////////////////////
    // Registers and state
    logic [ilf_pkg::LVL_W-1:0] thresh;
    logic [ilf_pkg::NEV-1:0] status;
    logic [ilf_pkg::NEV-1:0] mask;
    logic [1:0] div_cnt;
    logic link_tick;
    logic [3:0] burst_cnt;
    logic [ilf_pkg::CHAN_W-1:0] last_chan;
    logic tx_busy;
    logic rx_open;
    logic rx_bad;

    ////////////////////////////////////////////////////////////////
    // Transmit buffer
    wire tx_full;
    wire tx_empty;
    wire [ilf_pkg::TX_E_W-1:0] tx_head;
    wire [ilf_pkg::LVL_W-1:0] tx_level;
    wire c_max = burst_cnt == ilf_pkg::BURST_MAX;
    wire c_sop = tx_sop_in;
    wire c_chan = ~tx_sop_in & (tx_chan_in != last_chan);
    wire c_force = tx_bctl_in;
    wire [2:0] n_cause = 3'(c_max) + 3'(c_sop) + 3'(c_chan) + 3'(c_force);
    wire tx_bcw = n_cause != 3'h0;
    wire tx_multi = tx_ena_in & (n_cause > 3'h1);
    wire tx_overrun = tx_ena_in & tx_full;
    wire tx_pop = link_tick & ~tx_empty;
    wire tx_starve = link_tick & tx_empty & tx_busy;
    wire [ilf_pkg::TX_E_W-1:0] tx_word =
        {tx_chan_in, tx_bcw, tx_eop_in, tx_sop_in, tx_data_in};
    wire next_backpress = tx_level >= thresh;
    wire [3:0] next_burst_cnt = tx_bcw ? ilf_pkg::BURST_ONE : burst_cnt + 4'h1;

    ilf_fifo #(.W(ilf_pkg::TX_E_W)) u_tx_buf (
        .mclk_in(mclk_in),
        .nrst_in(nrst_in),
        .push_in(tx_ena_in),
        .din_in(tx_word),
        .full_out(tx_full),
        .pop_in(tx_pop),
        .dout_out(tx_head),
        .empty_out(tx_empty),
        .level_out(tx_level)
    );

    ////////////////////////////////////////////////////////////////
    // Receive buffer and packet repair
    wire rx_full;
    wire rx_empty;
    wire [ilf_pkg::RX_E_W-1:0] rx_head;
    wire [ilf_pkg::LVL_W-1:0] rx_level;
    wire rx_push = ln_rx_valid_in & ~rx_full;
    wire rx_lost = ln_rx_valid_in & rx_full;
    wire rx_pop = rx_rd_in & ~rx_empty;
    wire rx_orphan = ~rx_open & ~ln_rx_sop_in;
    wire rx_restart = rx_open & ln_rx_sop_in;
    wire next_rx_bad =
        (rx_open & ~ln_rx_sop_in & rx_bad) | ln_rx_err_in | rx_orphan | rx_restart;
    // Missing end: the second start is swallowed so both packets merge
    wire rx_sop_kept = ln_rx_sop_in & ~rx_open;
    wire [ilf_pkg::RX_E_W-1:0] rx_word =
        {next_rx_bad, ln_rx_eop_in, rx_sop_kept, ln_rx_data_in};
    wire rx_pkt_err = rx_push & ln_rx_eop_in & next_rx_bad;

    ilf_fifo #(.W(ilf_pkg::RX_E_W)) u_rx_buf (
        .mclk_in(mclk_in),
        .nrst_in(nrst_in),
        .push_in(rx_push),
        .din_in(rx_word),
        .full_out(rx_full),
        .pop_in(rx_pop),
        .dout_out(rx_head),
        .empty_out(rx_empty),
        .level_out(rx_level)
    );

    ////////////////////////////////////////////////////////////////
    // Register decode
    wire wr_ctrl = reg_wr_in & (reg_addr_in == ilf_pkg::ADDR_CTRL);
    wire wr_mask = reg_wr_in & (reg_addr_in == ilf_pkg::ADDR_MASK);
    wire rd_status = reg_rd_in & (reg_addr_in == ilf_pkg::ADDR_STATUS);
    wire [ilf_pkg::NEV-1:0] events;
    wire [ilf_pkg::NEV-1:0] next_status;
    logic [ilf_pkg::DATA_W-1:0] rd_mux;

    assign events[ilf_pkg::ST_TX_OVF] = tx_overrun;
    assign events[ilf_pkg::ST_TX_UDF] = tx_starve;
    assign events[ilf_pkg::ST_BURST] = tx_multi;
    assign events[ilf_pkg::ST_RX_OVF] = rx_lost;
    assign events[ilf_pkg::ST_RX_ERR] = rx_pkt_err;

    // Set beats the read-clear so no event is lost
    genvar gi;
    generate
        for (gi = 0; gi < ilf_pkg::NEV; gi++)
        begin : g_st
            assign next_status[gi] = events[gi] | (status[gi] & ~rd_status);
        end
    endgenerate

    always_comb
    begin
        if (reg_addr_in == ilf_pkg::ADDR_CTRL)
            rd_mux = ilf_pkg::DATA_W'(thresh);
        else if (reg_addr_in == ilf_pkg::ADDR_STATUS)
            rd_mux = ilf_pkg::DATA_W'(status);
        else if (reg_addr_in == ilf_pkg::ADDR_MASK)
            rd_mux = ilf_pkg::DATA_W'(mask);
        else if (reg_addr_in == ilf_pkg::ADDR_LEVEL)
            rd_mux = {11'h000, rx_level, 11'h000, tx_level};
        else
            rd_mux = '0;
    end

    ////////////////////////////////////////////////////////////////
    // Register file and interrupt
    always_ff @(posedge mclk_in or negedge nrst_in)
    begin
        if (!nrst_in)
        begin
            thresh <= ilf_pkg::THRESH_RST;
            mask <= ilf_pkg::MASK_RST;
            status <= '0;
            reg_rdata_out <= '0;
            irq_out <= 1'b0;
        end
        else
        begin
            if (wr_ctrl)
                thresh <= reg_wdata_in[ilf_pkg::LVL_W-1:0];
            if (wr_mask)
                mask <= reg_wdata_in[ilf_pkg::NEV-1:0];
            status <= next_status;
            reg_rdata_out <= reg_rd_in ? rd_mux : '0;
            irq_out <= |(next_status & mask);
        end
    end

    ////////////////////////////////////////////////////////////////
    // Transmit flow control and burst tracking
    always_ff @(posedge mclk_in or negedge nrst_in)
    begin
        if (!nrst_in)
        begin
            tx_backpress_out <= 1'b0;
            tx_ovf_out <= 1'b0;
            tx_underflow_out <= 1'b0;
            tx_burst_err_out <= 1'b0;
            burst_cnt <= '0;
            last_chan <= '0;
        end
        else
        begin
            tx_backpress_out <= next_backpress;
            // Only a reset clears it: data already lost
            if (tx_overrun)
                tx_ovf_out <= 1'b1;
            tx_underflow_out <= tx_starve;
            tx_burst_err_out <= tx_multi;
            if (tx_ena_in)
            begin
                burst_cnt <= next_burst_cnt;
                last_chan <= tx_chan_in;
            end
        end
    end

    ////////////////////////////////////////////////////////////////
    // Link drain at the slower link rate
    always_ff @(posedge mclk_in or negedge nrst_in)
    begin
        if (!nrst_in)
        begin
            div_cnt <= '0;
            link_tick <= 1'b0;
            tx_busy <= 1'b0;
            ln_tx_valid_out <= 1'b0;
            ln_tx_data_out <= '0;
            ln_tx_sop_out <= 1'b0;
            ln_tx_eop_out <= 1'b0;
            ln_tx_bcw_out <= 1'b0;
            ln_tx_chan_out <= '0;
        end
        else
        begin
            div_cnt <= (div_cnt == ilf_pkg::LINK_DIV) ? 2'h0 : div_cnt + 2'h1;
            link_tick <= div_cnt == ilf_pkg::LINK_DIV;
            ln_tx_valid_out <= tx_pop;
            if (tx_pop)
            begin
                ln_tx_data_out <= tx_head[ilf_pkg::WORD_W-1:0];
                ln_tx_sop_out <= tx_head[ilf_pkg::TXB_SOP];
                ln_tx_eop_out <= tx_head[ilf_pkg::TXB_EOP];
                ln_tx_bcw_out <= tx_head[ilf_pkg::TXB_BCW];
                ln_tx_chan_out <= tx_head[ilf_pkg::TX_E_W-1:ilf_pkg::TXB_CH];
                // Burst open from a start until its end leaves
                if (tx_head[ilf_pkg::TXB_EOP])
                    tx_busy <= 1'b0;
                else if (tx_head[ilf_pkg::TXB_SOP])
                    tx_busy <= 1'b1;
            end
        end
    end

    ////////////////////////////////////////////////////////////////
    // Receive packet tracking and delivery
    always_ff @(posedge mclk_in or negedge nrst_in)
    begin
        if (!nrst_in)
        begin
            rx_open <= 1'b0;
            rx_bad <= 1'b0;
            rx_overflow_out <= 1'b0;
            rx_ena_out <= 1'b0;
            rx_data_out <= '0;
            rx_sop_out <= 1'b0;
            rx_eop_out <= 1'b0;
            rx_err_out <= 1'b0;
        end
        else
        begin
            rx_overflow_out <= rx_lost;
            if (rx_push)
            begin
                rx_open <= ~ln_rx_eop_in;
                rx_bad <= next_rx_bad & ~ln_rx_eop_in;
            end
            rx_ena_out <= rx_pop;
            if (rx_pop)
            begin
                rx_data_out <= rx_head[ilf_pkg::WORD_W-1:0];
                rx_sop_out <= rx_head[ilf_pkg::RXB_SOP];
                rx_eop_out <= rx_head[ilf_pkg::RXB_EOP];
                rx_err_out <= rx_head[ilf_pkg::RXB_ERR];
            end
        end
    end

    ////////////////////////////////////////////////////////////////
    // Checks
    sequence s_tx_overrun;
        tx_ena_in && tx_full;
    endsequence

    sequence s_rx_orphan;
        ln_rx_valid_in && !rx_full && !rx_open && !ln_rx_sop_in && !ln_rx_eop_in;
    endsequence

    a_backpress_level: assert property (@(posedge mclk_in) disable iff (!nrst_in)
        tx_backpress_out == ($past(tx_level) >= $past(thresh)))
        else $error("back-pressure does not follow fill threshold");

    a_ovf_set: assert property (@(posedge mclk_in) disable iff (!nrst_in)
        s_tx_overrun |=> tx_ovf_out)
        else $error("overrun not flagged");

    a_ovf_sticky: assert property (@(posedge mclk_in) disable iff (!nrst_in)
        tx_ovf_out |=> tx_ovf_out [*8])
        else $error("overrun flag dropped before reset");

    a_udf_flag: assert property (@(posedge mclk_in) disable iff (!nrst_in)
        (link_tick && tx_empty && tx_busy) |=> tx_underflow_out)
        else $error("underflow not flagged");

    a_burst_multi: assert property (@(posedge mclk_in) disable iff (!nrst_in)
        tx_burst_err_out == $past(tx_ena_in && (n_cause > 3'h1)))
        else $error("burst error mismatch");

    a_bcw_restart: assert property (@(posedge mclk_in) disable iff (!nrst_in)
        (tx_ena_in && (tx_sop_in || tx_bctl_in)) |=> burst_cnt == ilf_pkg::BURST_ONE)
        else $error("control word did not restart burst count");

    a_rx_ovf_flag: assert property (@(posedge mclk_in) disable iff (!nrst_in)
        (ln_rx_valid_in && rx_full) |=> rx_overflow_out)
        else $error("receive overflow not flagged");

    a_rx_orphan_err: assert property (@(posedge mclk_in) disable iff (!nrst_in)
        s_rx_orphan |=> rx_open && rx_bad)
        else $error("packet without start not marked bad");

    a_rx_err_out: assert property (@(posedge mclk_in) disable iff (!nrst_in)
        (rx_pop && rx_head[ilf_pkg::RXB_ERR]) |=> rx_ena_out && rx_err_out)
        else $error("error word delivered without error output");
endmodule
`default_nettype wire

// [core/ilf_fifo.sv]
// Synchronous word buffer with fill level
`timescale 1ns/10ps
`default_nettype none
module ilf_fifo #(
    parameter int W = 32
) (
    // Clock and reset
    input wire logic mclk_in,
    input wire logic nrst_in,
    // Fill side
    input wire logic push_in,
    input wire logic [W-1:0] din_in,
    output logic full_out,
    // Drain side
    input wire logic pop_in,
    output logic [W-1:0] dout_out,
    output logic empty_out,
    output logic [ilf_pkg::LVL_W-1:0] level_out
);
    logic [W-1:0] mem [ilf_pkg::DEPTH];
    logic [ilf_pkg::PTR_W-1:0] wptr;
    logic [ilf_pkg::PTR_W-1:0] rptr;
    logic [ilf_pkg::LVL_W-1:0] cnt;
    wire do_push = push_in & ~full_out;
    wire do_pop = pop_in & ~empty_out;

    assign full_out = cnt == ilf_pkg::LVL_W'(ilf_pkg::DEPTH);
    assign empty_out = cnt == '0;
    assign dout_out = mem[rptr];
    assign level_out = cnt;

    ////////////////////////////////////////////////////////////////
    // No reset on storage: contents are don't-care while empty
    always_ff @(posedge mclk_in)
    begin
        if (do_push)
            mem[wptr] <= din_in;
    end

    always_ff @(posedge mclk_in or negedge nrst_in)
    begin
        if (!nrst_in)
        begin
            wptr <= '0;
            rptr <= '0;
            cnt <= '0;
        end
        else
        begin
            if (do_push)
                wptr <= wptr + 1'b1;
            if (do_pop)
                rptr <= rptr + 1'b1;
            if (do_push && !do_pop)
                cnt <= cnt + 1'b1;
            else if (do_pop && !do_push)
                cnt <= cnt - 1'b1;
        end
    end
endmodule
`default_nettype wire

// [dv/ilf_user.sv]
// Behavioural user logic on the transmit and receive local user bus
`timescale 1ns/10ps
`default_nettype none
module ilf_user (
    // Clock and commands
    input wire logic mclk_in,
    input wire logic go_in,
    input wire logic [5:0] len_in,
    input wire logic slow_in,
    input wire logic ign_bp_in,
    input wire logic dbl_in,
    input wire logic drain_in,
    input wire logic [ilf_pkg::CHAN_W-1:0] chan_in,
    input wire logic [ilf_pkg::WORD_W-1:0] seed_in,
    // Transmit local user bus
    input wire logic tx_backpress_in,
    output logic tx_ena_out,
    output logic [ilf_pkg::WORD_W-1:0] tx_data_out,
    output logic tx_sop_out,
    output logic tx_eop_out,
    output logic [ilf_pkg::CHAN_W-1:0] tx_chan_out,
    output logic tx_bctl_out,
    output logic busy_out,
    // Receive drain
    output logic rx_rd_out
);
    int left = 0;
    int idx = 0;
    int tick = 0;
    logic go_ok;
    ////////////////////////////////////////
    // Slow mode starves the link on purpose, only when commanded
    assign go_ok = (ign_bp_in || !tx_backpress_in) && (!slow_in || tick % 4 == 0);
    assign busy_out = left != 0;
    initial
    begin
        tx_ena_out = 1'h0;
        tx_data_out = 32'h0;
        tx_sop_out = 1'h0;
        tx_eop_out = 1'h0;
        tx_chan_out = 8'h00;
        tx_bctl_out = 1'h0;
        rx_rd_out = 1'h0;
    end
    ////////////////////////////////////////
    always @(posedge mclk_in)
    begin
        tick <= tick + 1;
        rx_rd_out <= drain_in;
        tx_chan_out <= chan_in;
        if (go_in)
        begin
            left <= int'(len_in);
            idx <= 0;
            tx_ena_out <= 1'h0;
        end
        else if (left != 0 && go_ok)
        begin
            tx_ena_out <= 1'h1;
            tx_data_out <= seed_in + 32'(idx);
            tx_sop_out <= idx == 0;
            tx_eop_out <= left == 1;
            tx_bctl_out <= dbl_in && idx == 0;
            left <= left - 1;
            idx <= idx + 1;
        end
        else
        begin
            // Released data keeps moving so stale words never look valid
            tx_ena_out <= 1'h0;
            tx_data_out <= ~tx_data_out;
        end
    end
endmodule
`default_nettype wire

// [dv/tb.sv]
// Self-checking bench of the local user bus flow control block
`timescale 1ns/10ps
`default_nettype none
module tb;
    logic mclk_in = 1'h0;
    logic nrst_in = 1'h0;
    logic [3:0] ra = 4'h0;
    logic [31:0] rwd = 32'h0;
    logic rwr = 1'h0;
    logic rrd = 1'h0;
    logic go = 1'h0;
    logic [5:0] len = 6'h00;
    logic slow = 1'h0;
    logic ign = 1'h0;
    logic dbl = 1'h0;
    logic drain = 1'h1;
    logic [7:0] chan = 8'h05;
    logic [31:0] seed = 32'h0000282E;
    logic xv = 1'h0;
    logic xs = 1'h0;
    logic xe = 1'h0;
    logic xr = 1'h0;
    logic [31:0] xd = 32'h0;
    logic [15:0] rs = 16'h282E;
    logic [31:0] d, rrdata, tdata, ldata, rdata;
    logic [7:0] tchan, lchan, lastch;
    logic irq, bp, ovf, udf, berr, tena, tsop, teop, tbctl, busy, urd;
    logic lv, lsop, leop, lbcw, rena, rsop, reop, rerr, rovf;
    logic bp_seen, ropen, rest;
    logic mdl_on = 1'h0;
    logic [42:0] tq[$];
    logic [42:0] rq[$];
    int n_mismatch = 0;
    int checked = 0;
    int n_berr, n_eberr, n_udf, n_rovf, n_erovf, cnt, c;
    localparam logic [2:0] RXP [8] = '{3'h4, 3'h1, 3'h2, 3'h0, 3'h2, 3'h4, 3'h6, 3'h6};
    ////////////////////////////////////////
    ilf_core dut (
        .mclk_in(mclk_in), .nrst_in(nrst_in), .reg_addr_in(ra), .reg_wdata_in(rwd),
        .reg_wr_in(rwr), .reg_rd_in(rrd), .reg_rdata_out(rrdata), .irq_out(irq),
        .tx_ena_in(tena), .tx_data_in(tdata), .tx_sop_in(tsop), .tx_eop_in(teop),
        .tx_chan_in(tchan), .tx_bctl_in(tbctl), .tx_backpress_out(bp), .tx_ovf_out(ovf),
        .tx_underflow_out(udf), .tx_burst_err_out(berr), .ln_tx_valid_out(lv),
        .ln_tx_data_out(ldata), .ln_tx_sop_out(lsop), .ln_tx_eop_out(leop),
        .ln_tx_bcw_out(lbcw), .ln_tx_chan_out(lchan), .ln_rx_valid_in(xv),
        .ln_rx_data_in(xd), .ln_rx_sop_in(xs), .ln_rx_eop_in(xe), .ln_rx_err_in(xr),
        .rx_rd_in(urd), .rx_ena_out(rena), .rx_data_out(rdata), .rx_sop_out(rsop),
        .rx_eop_out(reop), .rx_err_out(rerr), .rx_overflow_out(rovf)
    );
    ilf_user usr (
        .mclk_in(mclk_in), .go_in(go), .len_in(len), .slow_in(slow), .ign_bp_in(ign),
        .dbl_in(dbl), .drain_in(drain), .chan_in(chan), .seed_in(seed),
        .tx_backpress_in(bp), .tx_ena_out(tena), .tx_data_out(tdata), .tx_sop_out(tsop),
        .tx_eop_out(teop), .tx_chan_out(tchan), .tx_bctl_out(tbctl), .busy_out(busy),
        .rx_rd_out(urd)
    );
    always #10 mclk_in = ~mclk_in;
    ////////////////////////////////////////
    function automatic logic [15:0] lfsr(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction
    task automatic chk(input string nm, input logic [42:0] e, input logic [42:0] g);
        checked++;
        if (g !== e)
        begin
            n_mismatch++;
            $display("BAD %s exp %h got %h", nm, e, g);
        end
    endtask
    task automatic end_sim();
        $display("checked %0d n_mismatch %0d", checked, n_mismatch);
        if (n_mismatch == 0 && checked > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    task automatic do_reset();
        nrst_in <= 1'h0;
        repeat (16) @(posedge mclk_in);
        tq.delete();
        rq.delete();
        {n_berr, n_eberr, n_udf, n_rovf, n_erovf, cnt} = 192'h0;
        {bp_seen, ropen, rest, mdl_on} = 4'h1;
        lastch = 8'h00;
        nrst_in <= 1'h1;
        @(posedge mclk_in);
        #1;
    endtask
    task automatic reg_wr(input logic [3:0] a, input logic [31:0] v);
        @(posedge mclk_in);
        ra <= a;
        rwd <= v;
        rwr <= 1'h1;
        @(posedge mclk_in);
        rwr <= 1'h0;
    endtask
    task automatic reg_rd(input logic [3:0] a, output logic [31:0] v);
        @(posedge mclk_in);
        ra <= a;
        rrd <= 1'h1;
        @(posedge mclk_in);
        rrd <= 1'h0;
        #1;
        v = rrdata;
    endtask
    task automatic tx_pkt(input int n, input logic [2:0] m);
        @(posedge mclk_in);
        go <= 1'h1;
        len <= n[5:0];
        {slow, ign, dbl} <= m;
        seed <= {seed[15:0], lfsr(seed[15:0])};
        @(posedge mclk_in);
        go <= 1'h0;
    endtask
    task automatic rx_word(input logic [2:0] w);
        @(posedge mclk_in);
        rs = lfsr(rs);
        xv <= 1'h1;
        xd <= {rs, ~rs};
        {xs, xe, xr} <= w;
        if (rq.size() >= ilf_pkg::DEPTH && !drain)
            n_erovf++;
        else
        begin
            rest = rest || w[0] || (w[2] == ropen);
            rq.push_back({8'h00, rest, w[1], w[2] && !ropen, rs, ~rs});
            ropen = !w[1];
            rest = rest && !w[1];
        end
    endtask
    task automatic rx_idle();
        @(posedge mclk_in);
        xv <= 1'h0;
        xd <= ~xd;
    endtask
    task automatic settle(input string nm);
        int i;
        #1;
        for (i = 0; i < 600 && (busy || tena || tq.size() != 0 || (drain && rq.size() != 0)); i++)
        begin
            @(posedge mclk_in);
            #1;
        end
        if (i == 600)
        begin
            chk("settle", 1'h0, 1'h1);
            end_sim();
        end
        repeat (4) @(posedge mclk_in);
        #1;
        $display("test %s done", nm);
    endtask
    ////////////////////////////////////////
    // Reference model: sampled on the same edge the design takes the word
    always @(posedge mclk_in)
    begin
        if (bp) bp_seen = 1'h1;
        if (berr) n_berr++;
        if (udf) n_udf++;
        if (rovf) n_rovf++;
        if (mdl_on && tena)
        begin
            c = tsop + (cnt == ilf_pkg::BURST_MAX) + tbctl;
            c = c + (!tsop && tchan != lastch);
            if (c > 1) n_eberr++;
            tq.push_back({tchan, c != 0, teop, tsop, tdata});
            cnt = c != 0 ? 1 : cnt + 1;
            lastch = tchan;
        end
        if (mdl_on && lv) chk("link", tq.size() ? tq.pop_front() : 43'h0, {lchan, lbcw, leop, lsop, ldata});
        if (rena) chk("rx", rq.size() ? rq.pop_front() : 43'h0, {8'h00, rerr, reop, rsop, rdata});
    end
    ////////////////////////////////////////
    initial
    begin
        do_reset();
        chk("overrun", 1'h0, ovf);
        reg_rd(ilf_pkg::ADDR_CTRL, d);
        chk("ctrl", 32'(ilf_pkg::THRESH_RST), d);
        reg_rd(ilf_pkg::ADDR_MASK, d);
        chk("mask", 32'h0, d);
        reg_wr(ilf_pkg::ADDR_LEVEL, 32'hFFFFFFFF);
        reg_rd(ilf_pkg::ADDR_LEVEL, d);
        chk("level", 32'h0, d);
        reg_rd(4'hF, d);
        chk("unmapped", 32'h0, d);
        $display("test regs done");
        tx_pkt(10, 3'h0);
        settle("flow default");
        chk("backpress", 1'h0, bp_seen);
        reg_wr(ilf_pkg::ADDR_CTRL, 32'h00000004);
        bp_seen = 1'h0;
        tx_pkt(10, 3'h0);
        settle("flow low");
        chk("backpress", 1'h1, bp_seen);
        chk("overrun", 1'h0, ovf);
        chk("underflow", 32'h0, n_udf);
        tx_pkt(8, 3'h0);
        settle("burst eight");
        tx_pkt(3, 3'h0);
        settle("burst collide");
        tx_pkt(3, 3'h1);
        settle("burst forced");
        chk("burst errors", n_eberr, n_berr);
        fork
            tx_pkt(10, 3'h4);
            begin
                repeat (14) @(posedge mclk_in);
                chan <= chan + 8'h01;
            end
        join
        settle("slow link");
        chk("underflow", 1'h1, n_udf != 0);
        chk("burst errors", n_eberr, n_berr);
        for (int i = 0; i < 8; i++) rx_word(RXP[i]);
        rx_idle();
        settle("rx recovery");
        drain <= 1'h0;
        for (int i = 0; i < 17; i++) rx_word(i == 0 ? 3'h4 : 3'h0);
        rx_idle();
        repeat (3) @(posedge mclk_in);
        chk("rx overflow", n_erovf, n_rovf);
        // Full receive buffer must report exactly its depth
        reg_rd(ilf_pkg::ADDR_LEVEL, d);
        chk("level", 32'(ilf_pkg::DEPTH) << 16, d);
        drain <= 1'h1;
        settle("rx drain");
        rx_word(3'h2);
        rx_idle();
        settle("rx close");
        // Underflow, burst, rx overflow and rx error events all seen; no overrun yet
        reg_rd(ilf_pkg::ADDR_STATUS, d);
        chk("status", 32'h0000001E, d);
        do_reset();
        mdl_on = 1'h0;
        tx_pkt(40, 3'h2);
        settle("overrun");
        chk("overrun", 1'h1, ovf);
        chk("irq masked", 1'h0, irq);
        reg_wr(ilf_pkg::ADDR_MASK, 32'h00000001);
        repeat (2) @(posedge mclk_in);
        #1;
        chk("irq", 1'h1, irq);
        reg_rd(ilf_pkg::ADDR_STATUS, d);
        chk("status", 1'h1, d[ilf_pkg::ST_TX_OVF]);
        reg_rd(ilf_pkg::ADDR_STATUS, d);
        chk("status", 1'h0, d[ilf_pkg::ST_TX_OVF]);
        repeat (2) @(posedge mclk_in);
        #1;
        chk("irq", 1'h0, irq);
        chk("overrun", 1'h1, ovf);
        $display("test irq done");
        end_sim();
    end
endmodule
`default_nettype wire

// [pkg/ilf_pkg.sv]
// Constants for the local user bus flow control and error block
package ilf_pkg;
    // Register bus
    localparam int ADDR_W = 4;
    localparam int DATA_W = 32;
    localparam logic [3:0] ADDR_CTRL = 4'h0;
    localparam logic [3:0] ADDR_STATUS = 4'h1;
    localparam logic [3:0] ADDR_MASK = 4'h2;
    localparam logic [3:0] ADDR_LEVEL = 4'h3;
    // Status bits
    localparam int NEV = 5;
    localparam int ST_TX_OVF = 0;
    localparam int ST_TX_UDF = 1;
    localparam int ST_BURST = 2;
    localparam int ST_RX_OVF = 3;
    localparam int ST_RX_ERR = 4;
    localparam logic [4:0] MASK_RST = 5'h00;
    // Buffers
    localparam int WORD_W = 32;
    localparam int CHAN_W = 8;
    localparam int DEPTH = 16;
    localparam int PTR_W = 4;
    localparam int LVL_W = 5;
    localparam logic [4:0] THRESH_RST = 5'h0C;
    // Transmit entry: data, sop, eop, bcw, channel
    localparam int TX_E_W = 43;
    localparam int TXB_SOP = 32;
    localparam int TXB_EOP = 33;
    localparam int TXB_BCW = 34;
    localparam int TXB_CH = 35;
    // Receive entry: data, sop, eop, err
    localparam int RX_E_W = 35;
    localparam int RXB_SOP = 32;
    localparam int RXB_EOP = 33;
    localparam int RXB_ERR = 34;
    // Burst and link rate
    localparam logic [3:0] BURST_MAX = 4'h8;
    localparam logic [3:0] BURST_ONE = 4'h1;
    localparam logic [1:0] LINK_DIV = 2'h1;
endpackage
